// file: serial_expansion_port.v
/*
  serial_expansion_port: full-duplex 8-bit synchronous serial port with
  master and slave roles, programmable polarity, phase and bit order,
  and write-collision, slave overflow and mode-fault detection.
  assumes pins arrive asynchronous to sys_clk (10 MHz) and are synchronised
  here; pad enables are active low (oe_n low = driving).
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_expansion_port_map.vh"
module serial_expansion_port
(
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // control word and mode selects
  input wire [7:0] expansion_control_reg,
  input wire dma_mode,
  input wire [2:0] open_drain_sel,
  // data register access
  input wire data_wr,
  input wire [7:0] data_wr_val,
  input wire data_rd,
  output wire [7:0] expansion_data_reg,
  // status and flag clearing
  input wire status_clr,
  output reg xfer_end_ff,
  output reg rx_done_ff,
  output reg tx_done_ff,
  output reg wr_collision_ff,
  output reg overflow_ff,
  output reg mode_fault_ff,
  output reg busy_ff,
  output wire master_active,
  output wire rx_dma_req,
  output wire tx_dma_req,
  // serial_shift_clock pin
  input wire sclk_in,
  output reg sclk_out_ff,
  output wire sclk_oe_n,
  // data pins
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe_n,
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe_n,
  // slave select pin
  input wire ss_n_in
);

  localparam ST_IDLE = 2'h0;
  localparam ST_LEAD = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_DONE = 2'h3;

  // control decode
  wire [1:0] rate_sel = expansion_control_reg[`CTL_RATE_HI:`CTL_RATE_LO];
  wire cpha = expansion_control_reg[`CTL_CPHA];
  wire cpol = expansion_control_reg[`CTL_CPOL];
  wire master_sel = expansion_control_reg[`CTL_MSTR];
  wire bit_order_select = expansion_control_reg[`CTL_BIT_ORDER];
  wire port_enable = expansion_control_reg[`CTL_SEE];
  wire fault_detect_off = expansion_control_reg[`CTL_MODE];

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] div_ff;
  reg [3:0] nxt_div;
  reg [3:0] edge_cnt_ff;
  reg [3:0] nxt_edge_cnt;
  reg [7:0] sh_ff;
  reg [7:0] nxt_sh;
  reg out_bit_ff;
  reg nxt_out_bit;
  reg nxt_sclk;
  reg sync_sclk_a_ff;
  reg sync_sclk_b_ff;
  reg sclk_prev_ff;
  reg sync_ss_a_ff;
  reg sync_ss_b_ff;
  reg sync_mosi_a_ff;
  reg sync_mosi_b_ff;
  reg sync_miso_a_ff;
  reg sync_miso_b_ff;
  reg slave_selected_ff;
  reg [3:0] slv_cnt_ff;
  reg [3:0] nxt_slv_cnt;
  reg rx_load;
  reg [1:0] smp_dly_ff;
  wire [7:0] word_q;

  // picks the outgoing bit of a word for a given bit index and order
  function pick_bit;
    input [7:0] w;
    input [2:0] idx;
    input lsb_first;
    begin
      if (lsb_first)
        pick_bit = w[idx];
      else
        pick_bit = w[`LAST_BIT - idx];
    end
  endfunction

  // inserts one received bit at the end that fits the bit order
  function [7:0] shift_in;
    input [7:0] w;
    input b;
    input lsb_first;
    begin
      if (lsb_first)
        shift_in = {b, w[7:1]};
      else
        shift_in = {w[6:0], b};
    end
  endfunction

  // half-period of the shift clock in system clocks
  function [3:0] half_period;
    input [1:0] sel;
    begin
      case (sel)
        `RATE_DIV2: half_period = `HALF_DIV2;
        `RATE_DIV4: half_period = `HALF_DIV4;
        `RATE_DIV16: half_period = `HALF_DIV16;
        default: half_period = `HALF_DIV2;
      endcase
    end
  endfunction

  // two-flop synchronisers for all pin inputs; the first stage feeds only the second
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync_sclk_a_ff <= 1'b0;
      sync_sclk_b_ff <= 1'b0;
      sync_ss_a_ff <= 1'b1;
      sync_ss_b_ff <= 1'b1;
      sync_mosi_a_ff <= 1'b0;
      sync_mosi_b_ff <= 1'b0;
      sync_miso_a_ff <= 1'b0;
      sync_miso_b_ff <= 1'b0;
    end
    else
    begin
      sync_sclk_a_ff <= sclk_in;
      sync_sclk_b_ff <= sync_sclk_a_ff;
      sync_ss_a_ff <= ss_n_in;
      sync_ss_b_ff <= sync_ss_a_ff;
      sync_mosi_a_ff <= mosi_in;
      sync_mosi_b_ff <= sync_mosi_a_ff;
      sync_miso_a_ff <= miso_in;
      sync_miso_b_ff <= sync_miso_a_ff;
    end
  end

  wire ss_low = ~sync_ss_b_ff;
  // mode fault: master, detection enabled, select pulled low
  wire fault_now = port_enable & master_sel & ~fault_detect_off & ss_low;
  assign master_active = port_enable & master_sel & ~mode_fault_ff;
  wire slave_active = port_enable & ~master_sel;

  // slave edge detection on the synchronised clock
  wire sclk_rise = sync_sclk_b_ff & ~sclk_prev_ff;
  wire sclk_fall = ~sync_sclk_b_ff & sclk_prev_ff;
  // leading edge is rise for cpol 0, fall for cpol 1
  wire lead_edge = cpol ? sclk_fall : sclk_rise;
  wire trail_edge = cpol ? sclk_rise : sclk_fall;
  // phase 0 samples on leading edge, phase 1 on trailing
  wire slv_sample = slave_selected_ff & (cpha ? trail_edge : lead_edge);
  wire slv_shift = slave_selected_ff & (cpha ? lead_edge : trail_edge);
  wire slv_bit_in = sync_mosi_b_ff;
  wire mst_bit_in = sync_miso_b_ff;

  // a data write while a byte is moving collides and is not stored
  wire collide = data_wr & (busy_ff | (slave_active & ~cpha & ss_low));
  wire write_ok = data_wr & ~collide;
  wire mst_start = write_ok & master_active & (state_ff == ST_IDLE);
  wire half_tick = (div_ff == 4'h1);

  // master sequencer: lead-in half period, then 16 clock edges
  always @*
  begin
    nxt_state = state_ff;
    nxt_div = div_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_sclk = sclk_out_ff;
    rx_load = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_sclk = cpol; // idle level follows polarity
        nxt_edge_cnt = 4'h0;
        if (mst_start)
        begin
          nxt_state = ST_LEAD; // phase 0 first bit now valid
          nxt_div = half_period(rate_sel);
        end
      end
      ST_LEAD:
      begin
        nxt_div = div_ff - 4'h1;
        if (half_tick)
        begin
          nxt_state = ST_RUN;
          nxt_sclk = ~sclk_out_ff;
          nxt_div = half_period(rate_sel);
        end
      end
      ST_RUN:
      begin
        nxt_div = div_ff - 4'h1;
        if (half_tick)
        begin
          nxt_div = half_period(rate_sel);
          nxt_edge_cnt = edge_cnt_ff + 4'h1;
          if (edge_cnt_ff == 4'hf)
          begin
            nxt_state = ST_DONE; // a half period after the sixteenth edge closes the frame
            nxt_sclk = cpol;
          end
          else
            nxt_sclk = ~sclk_out_ff;
        end
      end
      ST_DONE:
      begin
        rx_load = 1'b1;
        nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    // fault or disable aborts at once
    if (!master_active)
    begin
      nxt_state = ST_IDLE;
      nxt_sclk = cpol;
      rx_load = 1'b0;
    end
    // slave completes its word on the eighth sample edge
    if (slave_active && slv_sample && slv_cnt_ff == `BITS_PER_WORD - 4'h1)
      rx_load = 1'b1;
  end

  // master edge decode: the lead-in ends with edge 1 and run count k makes edge k+2,
  // so odd k are leading edges and even k trailing ones; k=15 only closes the frame
  wire mst_first_edge = (state_ff == ST_LEAD) & half_tick;
  wire mst_edge = (state_ff == ST_RUN) & half_tick;
  wire mst_sample = (mst_first_edge & ~cpha) | (mst_edge & (edge_cnt_ff[0] != cpha) & (edge_cnt_ff != 4'hf));
  wire mst_shift = mst_edge & (edge_cnt_ff[0] == cpha) & (edge_cnt_ff[3:1] != `LAST_BIT);
  wire [2:0] mst_idx = edge_cnt_ff[3:1] + 3'h1;

  // shift/sample datapath for both roles
  always @*
  begin
    nxt_sh = sh_ff;
    nxt_out_bit = out_bit_ff;
    nxt_slv_cnt = slv_cnt_ff;
    if (mst_start)
    begin
      nxt_sh = 8'h00;
      // phase 1 keeps the old bit until the first clock edge
      if (!cpha)
        nxt_out_bit = pick_bit(data_wr_val, 3'h0, bit_order_select);
    end
    else if (master_active)
    begin
      if (smp_dly_ff[1])
        nxt_sh = shift_in(sh_ff, mst_bit_in, bit_order_select);
      if (mst_first_edge && cpha)
        nxt_out_bit = pick_bit(word_q, 3'h0, bit_order_select);
      else if (mst_shift)
        nxt_out_bit = pick_bit(word_q, mst_idx, bit_order_select);
    end
    else if (slave_active)
    begin
      if (!slave_selected_ff)
      begin
        nxt_slv_cnt = 4'h0;
        nxt_out_bit = pick_bit(word_q, 3'h0, bit_order_select);
      end
      else
      begin
        if (slv_sample)
        begin
          nxt_sh = shift_in(sh_ff, slv_bit_in, bit_order_select);
          nxt_slv_cnt = (slv_cnt_ff == `BITS_PER_WORD - 4'h1) ? 4'h0 : slv_cnt_ff + 4'h1;
        end
        if (slv_shift && slv_cnt_ff != 4'h0)
          nxt_out_bit = pick_bit(word_q, slv_cnt_ff[2:0], bit_order_select);
        else if (cpha && slv_shift)
          nxt_out_bit = pick_bit(word_q, 3'h0, bit_order_select);
      end
    end
  end

  // sequencer and datapath registers
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      div_ff <= 4'h0;
      edge_cnt_ff <= 4'h0;
      sclk_out_ff <= 1'b0;
      sh_ff <= 8'h00;
      out_bit_ff <= 1'b0;
      slv_cnt_ff <= 4'h0;
      sclk_prev_ff <= 1'b0;
      slave_selected_ff <= 1'b0;
      smp_dly_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      edge_cnt_ff <= nxt_edge_cnt;
      sclk_out_ff <= nxt_sclk;
      sh_ff <= nxt_sh;
      out_bit_ff <= nxt_out_bit;
      slv_cnt_ff <= nxt_slv_cnt;
      sclk_prev_ff <= sync_sclk_b_ff;
      slave_selected_ff <= slave_active & ss_low;
      // miso reaches the sampler two synchroniser flops late, so the strobe waits as long
      smp_dly_ff <= {smp_dly_ff[0], mst_sample};
    end
  end

  // at the fastest rate with phase 1 the last delayed master sample lands in the done cycle
  wire [7:0] rx_word = (state_ff == ST_DONE) ? nxt_sh : shift_in(sh_ff, slv_bit_in, bit_order_select);

  // data word storage
  shift_word_reg u_word
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(write_ok),
    .wr_data(data_wr_val),
    .rx_load(rx_load),
    .rx_data(rx_word),
    .word_ff(word_q)
  );
  assign expansion_data_reg = word_q;

  // flags: hardware set wins over a clear in the same cycle
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      xfer_end_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      tx_done_ff <= 1'b0;
      wr_collision_ff <= 1'b0;
      overflow_ff <= 1'b0;
      mode_fault_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= (nxt_state != ST_IDLE) | (slave_active & ss_low & (nxt_slv_cnt != 4'h0));
      if (rx_load && !dma_mode)
        xfer_end_ff <= 1'b1;
      else if (status_clr || data_rd || data_wr)
        xfer_end_ff <= 1'b0;
      if (rx_load && dma_mode)
        rx_done_ff <= 1'b1;
      else if (status_clr || data_rd)
        rx_done_ff <= 1'b0;
      if (rx_load && dma_mode)
        tx_done_ff <= 1'b1;
      else if (status_clr || data_wr)
        tx_done_ff <= 1'b0;
      if (collide)
        wr_collision_ff <= 1'b1;
      else if (status_clr)
        wr_collision_ff <= 1'b0;
      if (rx_load && slave_active && (xfer_end_ff || rx_done_ff))
        overflow_ff <= 1'b1;
      else if (status_clr)
        overflow_ff <= 1'b0;
      if (fault_now)
        mode_fault_ff <= 1'b1;
      else if (status_clr)
        mode_fault_ff <= 1'b0;
    end
  end

  // dma requests follow the completion flags only in dma mode
  assign rx_dma_req = dma_mode & rx_done_ff;
  assign tx_dma_req = dma_mode & tx_done_ff;

  // pad drive: open-drain pins only pull low, releasing for a one
  wire drive_master = master_active & ~fault_now;
  wire drive_miso = slave_selected_ff;
  assign sclk_oe_n = ~(drive_master & (~open_drain_sel[0] | ~sclk_out_ff));
  assign mosi_out = out_bit_ff;
  assign mosi_oe_n = ~(drive_master & (~open_drain_sel[2] | ~out_bit_ff));
  assign miso_out = out_bit_ff;
  assign miso_oe_n = ~(drive_miso & (~open_drain_sel[1] | ~out_bit_ff));

endmodule // serial_expansion_port
`default_nettype wire

// file: serial_expansion_port_map.vh
/*
  constants for the serial expansion port: control bit positions, reset
  values, rate selections and timing counts.
  assumes a 10 MHz system clock; included by bare name.
*/
`ifndef SERIAL_EXPANSION_PORT_MAP_VH
`define SERIAL_EXPANSION_PORT_MAP_VH

// control word bit positions
`define CTL_RATE_LO 0
`define CTL_RATE_HI 1
`define CTL_CPHA 2
`define CTL_CPOL 3
`define CTL_MSTR 4
`define CTL_BIT_ORDER 5
`define CTL_SEE 6
`define CTL_MODE 7
`define CTL_RESET 8'h07

// rate selections (system clock divided by 2, 4 or 16)
`define RATE_DIV2 2'h1
`define RATE_DIV4 2'h2
`define RATE_DIV16 2'h3

// half shift-clock periods in system clocks for each rate
`define HALF_DIV2 4'h1
`define HALF_DIV4 4'h2
`define HALF_DIV16 4'h8

`define BITS_PER_WORD 4'h8
`define LAST_BIT 3'h7

`endif

// file: shift_word_reg.v
/*
  shift_word_reg: the 8-bit data word that is both the transmit source and
  the receive destination; read data come out of a register.
  assumes one clock domain, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module shift_word_reg
(
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // software write
  input wire wr_en,
  input wire [7:0] wr_data,
  // end-of-transfer load of received bits
  input wire rx_load,
  input wire [7:0] rx_data,
  // stored word
  output reg [7:0] word_ff
);

  // received data replace the word; a software write in the same cycle
  // is a collision and is dropped by the caller
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      word_ff <= 8'h00;
    else if (rx_load)
      word_ff <= rx_data;
    else if (wr_en)
      word_ff <= wr_data;
  end

endmodule // shift_word_reg
`default_nettype wire

// file: sep_checker_sva.sv
/*
  pin and flag checker for the serial expansion port, bound to its top module.
  assumes one sys_clk domain and rst_n synchronous, active low.
*/
`timescale 1ns/1ps
`default_nettype none
module sep_checker
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // controls
  input wire logic [7:0] expansion_control_reg,
  input wire logic dma_mode,
  input wire logic [2:0] open_drain_sel,
  input wire logic data_wr,
  input wire logic ss_n_in,
  // watched outputs
  input wire logic xfer_end_ff,
  input wire logic rx_done_ff,
  input wire logic wr_collision_ff,
  input wire logic overflow_ff,
  input wire logic mode_fault_ff,
  input wire logic busy_ff,
  input wire logic master_active,
  input wire logic sclk_out_ff,
  input wire logic sclk_oe_n,
  input wire logic mosi_out,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] rise_cnt_ff;
  logic sclk_prev_ff;
  wire [7:0] ctl = expansion_control_reg;
  wire end_flag = dma_mode ? rx_done_ff : xfer_end_ff;
  wire wr_start = data_wr && master_active && !busy_ff;
  // count clock rises inside one transfer; a lost or extra edge shows at the end
  always @(posedge sys_clk)
  begin
    sclk_prev_ff <= sclk_out_ff;
    if (!rst_n || !busy_ff)
      rise_cnt_ff <= 4'h0;
    else if (sclk_out_ff && !sclk_prev_ff)
      rise_cnt_ff <= rise_cnt_ff + 4'h1;
  end
  latency_fast_a: assert property (wr_start && ctl[1:0] < 2'h2 |-> ##1 busy_ff ##17 !end_flag ##1 end_flag)
    else $error("end flag not on time");
  eight_clocks_a: assert property ($fell(busy_ff) && ctl[4] && !ctl[3] && !mode_fault_ff |-> rise_cnt_ff == 4'h8)
    else $error("clock count not eight");
  idle_level_a: assert property (!busy_ff && $past(!busy_ff) && $past(rst_n) && master_active && $stable(ctl)
    |-> sclk_out_ff == ctl[3])
    else $error("idle clock level wrong");
  fault_detect_a: assert property ((!ss_n_in && master_active && !ctl[7])[*3] |-> ##[0:2] mode_fault_ff)
    else $error("mode fault missed");
  fault_release_a: assert property (mode_fault_ff |-> sclk_oe_n && mosi_oe_n && !master_active)
    else $error("drivers on after fault");
  fault_enable_a: assert property ($rose(mode_fault_ff) |-> !$past(ctl[7]) && $past(ctl[4]))
    else $error("fault while detection off");
  slave_float_a: assert property ((ss_n_in && !ctl[4])[*4] |-> miso_oe_n)
    else $error("deselected slave drives");
  slave_pins_a: assert property (!ctl[4] && $past(!ctl[4]) |-> sclk_oe_n && mosi_oe_n)
    else $error("slave drives clock or mosi");
  master_miso_a: assert property (master_active && $past(master_active) |-> miso_oe_n)
    else $error("master drives miso");
  open_drain_a: assert property (!mosi_oe_n && open_drain_sel[2] |-> !mosi_out)
    else $error("open drain drives high");
  write_collide_a: assert property (data_wr && busy_ff |=> wr_collision_ff)
    else $error("collision not flagged");
  overflow_slave_a: assert property ($rose(overflow_ff) |-> !ctl[4])
    else $error("overflow in master role");
  cover property (wr_start);
  cover property ($rose(mode_fault_ff));
  cover property ($rose(overflow_ff));
  cover property ($rose(wr_collision_ff));
endmodule // sep_checker
bind serial_expansion_port sep_checker i_chk (.sys_clk, .rst_n, .expansion_control_reg, .dma_mode,
  .open_drain_sel, .data_wr, .ss_n_in, .xfer_end_ff, .rx_done_ff, .wr_collision_ff, .overflow_ff,
  .mode_fault_ff, .busy_ff, .master_active, .sclk_out_ff, .sclk_oe_n, .mosi_out, .mosi_oe_n, .miso_oe_n);
`default_nettype wire

// file: far_slave_model.sv
/*
  behavioural far-side slave used while the device is master.
  assumes the bench drives its select and that idle lines are pulled high.
*/
`timescale 1ns/1ps
`default_nettype none
module far_slave_model
(
  // pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // setup shared with the device
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  integer n = 0;
  initial miso = 1'b1;
  // phase 0 needs the first bit out before any clock edge
  always @(negedge sel_n)
  begin
    n = 0;
    if (!cpha)
      miso = tx_byte[lsb_first ? 0 : 7];
  end
  // released line returns to the pull-up level
  always @(posedge sel_n)
    miso = 1'b1;
  // same polarity and phase as the device: one edge samples, the other shifts
  always @(sclk)
    if (!sel_n && n < 8)
    begin
      if ((sclk != cpol) ^ cpha)
      begin
        rx_byte[lsb_first ? n : 7 - n] = mosi;
        n = n + 1;
      end
      else
        miso = tx_byte[lsb_first ? n : 7 - n];
    end
endmodule // far_slave_model
`default_nettype wire

// file: test_serial_expansion_port.sv
/*
  self-checking bench: master runs against the far slave model, slave runs
  against a bench-made 800 ns link clock. assumes the checker binds itself.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serial_expansion_port;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ctl = 8'h07;
  logic dma_mode = 1'b0;
  logic [2:0] open_drain_sel = 3'h0;
  logic data_wr = 1'b0;
  logic [7:0] data_wr_val = 8'h00;
  logic data_rd = 1'b0;
  logic status_clr = 1'b0;
  logic ss_n_in = 1'b1;
  logic part_sel_n = 1'b1;
  logic ext_sclk = 1'b0;
  logic ext_mosi = 1'b1;
  logic [7:0] part_tx = 8'h00;
  logic [7:0] part_rx;
  logic part_miso;
  integer fails = 0;
  integer samples_checked = 0;
  integer seed_val, i, n;
  logic [7:0] sd, mo, got;
  wire [7:0] expansion_data_reg;
  wire xfer_end_ff, rx_done_ff, tx_done_ff, wr_collision_ff, overflow_ff, mode_fault_ff, busy_ff;
  wire master_active, rx_dma_req, tx_dma_req, sclk_out_ff, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  // every line has a pull-up, so a released driver leaves it high
  wire sclk_w = sclk_oe_n ? 1'b1 : sclk_out_ff;
  wire mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
  wire miso_w = !miso_oe_n ? miso_out : (part_sel_n ? 1'b1 : part_miso);
  initial forever #50 sys_clk = ~sys_clk;
  serial_expansion_port i_dut (.sys_clk, .rst_n, .expansion_control_reg(ctl), .dma_mode, .open_drain_sel,
    .data_wr, .data_wr_val, .data_rd, .expansion_data_reg, .status_clr, .xfer_end_ff, .rx_done_ff,
    .tx_done_ff, .wr_collision_ff, .overflow_ff, .mode_fault_ff, .busy_ff, .master_active, .rx_dma_req,
    .tx_dma_req, .sclk_in(ctl[4] ? sclk_w : ext_sclk), .sclk_out_ff, .sclk_oe_n,
    .mosi_in(ctl[4] ? mosi_w : ext_mosi), .mosi_out, .mosi_oe_n, .miso_in(miso_w), .miso_out, .miso_oe_n,
    .ss_n_in);
  far_slave_model i_far (.sclk(sclk_w), .mosi(mosi_w), .sel_n(part_sel_n), .miso(part_miso), .cpol(ctl[3]),
    .cpha(ctl[2]), .lsb_first(ctl[5]), .tx_byte(part_tx), .rx_byte(part_rx));
  task end_of_test;
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check_val(input logic [7:0] got_v, input logic [7:0] exp_v, input string what);
    samples_checked = samples_checked + 1;
    if (got_v !== exp_v)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got_v, exp_v);
    end
  endtask
  task check_num(input integer got_n, input integer exp_n, input string what);
    samples_checked = samples_checked + 1;
    if (got_n != exp_n)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: %s got %0d want %0d", $time, what, got_n, exp_n);
    end
  endtask
  task pulse_wr(input logic [7:0] v);
    @(posedge sys_clk);
    data_wr <= 1'b1;
    data_wr_val <= v;
    @(posedge sys_clk);
    data_wr <= 1'b0;
  endtask
  task clear_all;
    @(posedge sys_clk);
    status_clr <= 1'b1;
    @(posedge sys_clk);
    status_clr <= 1'b0;
  endtask
  // counts edges until the end flag shows; a hang ends the run
  task wait_end(input integer n0, output integer cnt);
    cnt = n0;
    while ((dma_mode ? rx_done_ff : xfer_end_ff) !== 1'b1 && cnt < n0 + 400)
    begin
      @(posedge sys_clk);
      #1;
      cnt = cnt + 1;
    end
    if (cnt >= n0 + 400)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: no end flag", $time);
      end_of_test;
    end
  endtask
  task master_run(input logic [7:0] c, input logic dma, input logic coll);
    integer h;
    logic [7:0] d;
    d = 8'($urandom);
    h = (c[1:0] == 2'h2) ? 2 : (c[1:0] == 2'h3) ? 8 : 1;
    @(posedge sys_clk);
    ctl <= c;
    dma_mode <= dma;
    open_drain_sel <= 3'($urandom);
    part_tx <= 8'($urandom);
    clear_all;
    @(posedge sys_clk);
    part_sel_n <= 1'b0;
    pulse_wr(d);
    n = 0;
    // second write lands mid-transfer and must be refused
    if (coll)
    begin
      repeat (3) @(posedge sys_clk);
      pulse_wr(~d);
      n = 5;
    end
    wait_end(n, n);
    check_num(n, 17 * h + 1, "end latency");
    check_val(expansion_data_reg, part_tx, "master rx");
    check_val(part_rx, d, "master tx");
    check_val({4'h0, rx_dma_req, wr_collision_ff, xfer_end_ff, tx_dma_req}, {4'h0, dma, coll, !dma, dma}, "flags");
    @(posedge sys_clk);
    part_sel_n <= 1'b1;
  endtask
  // bench acts as external master; the pins are asynchronous to sys_clk
  task ext_byte(input logic [7:0] mo_v, output logic [7:0] so_v);
    integer k, p;
    @(posedge sys_clk);
    #37;
    // the link clock idles at the polarity level before the select falls
    ext_sclk = ctl[3];
    #400;
    ss_n_in = 1'b0;
    #800;
    for (k = 0; k < 8; k = k + 1)
    begin
      p = ctl[5] ? k : 7 - k;
      ext_sclk = ctl[2] ? ~ctl[3] : ctl[3];
      ext_mosi = mo_v[p];
      #400;
      so_v[p] = miso_w;
      ext_sclk = ctl[2] ? ctl[3] : ~ctl[3];
      #400;
    end
    ext_sclk = ctl[3];
    #400;
    ss_n_in = 1'b1;
    ext_mosi = 1'b1;
  endtask
  initial
  begin
    seed_val = $urandom(32'h0008);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check_val({xfer_end_ff, rx_done_ff, tx_done_ff, wr_collision_ff, overflow_ff, mode_fault_ff, busy_ff, 1'b0},
      8'h00, "reset flags");
    // every rate, polarity and phase; order, dma and open drain random
    for (i = 0; i < 16; i = i + 1)
      master_run({2'b01, 1'($urandom), 1'b1, 2'(i), 2'(i >> 2)}, 1'($urandom), i == 5 || i == 14);
    @(posedge sys_clk);
    ctl <= 8'h51;
    ss_n_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check_val({mode_fault_ff, master_active, sclk_oe_n, mosi_oe_n, 4'h0}, 8'hb0, "fault");
    @(posedge sys_clk);
    ss_n_in <= 1'b1;
    ctl <= 8'hd1;
    clear_all;
    @(posedge sys_clk);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check_val({7'h00, mode_fault_ff}, 8'h00, "fault off");
    @(posedge sys_clk);
    ss_n_in <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      sd = 8'($urandom);
      mo = 8'($urandom);
      @(posedge sys_clk);
      ctl <= {2'b01, 1'($urandom), 1'b0, 2'(i), 2'b01};
      dma_mode <= 1'b0;
      clear_all;
      pulse_wr(sd);
      ext_byte(mo, got);
      wait_end(0, n);
      check_val(expansion_data_reg, mo, "slave rx");
      check_val(got, sd, "slave tx");
      ext_byte(~mo, got);
      // the pins pass two synchroniser stages first
      repeat (6) @(posedge sys_clk);
      #1;
      check_val({7'h00, overflow_ff}, 8'h01, "overflow");
      @(posedge sys_clk);
      data_rd <= 1'b1;
      @(posedge sys_clk);
      data_rd <= 1'b0;
      #1;
      check_val({6'h00, xfer_end_ff, overflow_ff}, 8'h01, "read clear");
    end
    end_of_test;
  end
endmodule // test_serial_expansion_port
`default_nettype wire
